//--- logic/sdc_ctrl.sv
`timescale 1ns/1ps
module sdc_ctrl
   import sdc_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           rst,
   sdc_if.ctrl                 link,
   input  wire logic           req_valid,
   input  wire sdc_pkg::sdc_cmd_t req_cmd,
   input  wire logic [1:0]     req_bank,
   input  wire logic           req_apre,
   input  wire logic           req_cke,
   input  wire logic           req_mask,
   output logic                req_ready
);
   typedef struct packed {
      logic [7:0] div;
      logic       lclk;
      logic       cke;
      logic [2:0] stb;
      logic       cs_n;
      logic [1:0] bank;
      logic       apre;
      logic       mask;
      logic       ready;
   } sdc_cst_t;

   sdc_cst_t s_q, s_d;

   ////////////////////////////////////////////////////////////////////
   // Commands change on the falling link edge so the device sees them stable
   always_comb begin
      s_d = s_q;
      s_d.ready = 1'b0;
      if (s_q.div == 8'(CLK_DIV / 2 - 1)) begin
         s_d.div  = '0;
         s_d.lclk = ~s_q.lclk;
         if (s_q.lclk) begin // [R1]
            s_d.cs_n = 1'b1;
            s_d.stb  = STB_NOP;
            s_d.ready = 1'b1;
            if (req_valid) begin
               s_d.cke  = req_cke;
               s_d.bank = req_bank;
               s_d.apre = req_apre;
               s_d.mask = req_mask;
               s_d.cs_n = 1'b0;
               case (req_cmd) // [R2]
                  SDC_ACT:  s_d.stb = STB_ACT;
                  SDC_PRE:  s_d.stb = STB_PRE;
                  SDC_PREA: begin
                     s_d.stb  = STB_PRE;
                     s_d.apre = 1'b1;
                  end
                  SDC_WR:   s_d.stb = STB_WR;  // [R4] caller keeps bank active
                  SDC_RD:   s_d.stb = STB_RD;
                  SDC_MRS:  s_d.stb = STB_MRS;
                  SDC_BST:  s_d.stb = STB_BST; // [R5] caller keeps full page
                  SDC_REF, SDC_SREF: s_d.stb = STB_REF;
                  SDC_DESEL: s_d.cs_n = 1'b1;  // [R7] [R8]
                  default:  s_d.stb = STB_NOP;
               endcase
            end
         end
      end else begin
         s_d.div = s_q.div + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '{div: 8'h00, lclk: 1'b0, cke: 1'b1, stb: STB_NOP, cs_n: 1'b1,
                  bank: 2'h0, apre: 1'b0, mask: 1'b1, ready: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign link.link_clk             = s_q.lclk;
   assign link.clk_en               = s_q.cke;
   assign link.chip_sel_n           = s_q.cs_n;
   assign link.row_strobe_n         = s_q.stb[2];
   assign link.col_strobe_n         = s_q.stb[1];
   assign link.write_en_n           = s_q.stb[0];
   assign link.bank_select_lo       = s_q.bank[0];
   assign link.bank_select_hi       = s_q.bank[1];
   assign link.precharge_select_bit = s_q.apre;
   assign link.data_mask            = s_q.mask;
   assign req_ready                 = s_q.ready;
endmodule : sdc_ctrl

//--- logic/sdc_dev.sv
`timescale 1ns/1ps
module sdc_dev
   import sdc_pkg::*;
#(
   parameter int BURST_LEN = 4
)(
   input  wire logic                 clk,
   input  wire logic                 rst,
   sdc_if.dev                        link,
   input  wire logic                 full_page,
   output sdc_pkg::sdc_cmd_t         cmd_out,
   output logic                      cmd_stb,
   output logic [NUM_BANKS-1:0]      bank_open,
   output logic                      auto_pre,
   output sdc_pkg::sdc_mode_t        mode,
   output logic                      in_burst,
   output logic                      wr_capture_en,
   output logic                      rd_drive_en
);
   // Device logic runs on the link clock; the toggle carries events to clk
   typedef struct packed {
      logic                 cke_prev;
      sdc_mode_t            mode;
      logic                 susp_pend;
      logic                 res_pend;
      logic [NUM_BANKS-1:0] open;
      logic [7:0]           burst;
      logic                 apre;
      logic [BANK_W-1:0]    abank;
      logic [1:0]           fp_sync;
      sdc_cmd_t             cmd;
      logic                 tog;
      logic                 wr_en;
      logic                 rd_en;
   } sdc_dst_t;

   typedef struct packed {
      logic [2:0]           tsync;
      sdc_cmd_t             cmd;
      logic                 stb;
      logic [NUM_BANKS-1:0] open;
      logic                 apre;
      sdc_mode_t            mode;
      logic                 burst;
      logic                 wr;
      logic                 rd;
   } sdc_sst_t;

   sdc_dst_t l_q, l_d;
   sdc_sst_t c_q, c_d;

   function automatic logic [1:0] bank_of(input logic hi, input logic lo);
      return {hi, lo};
   endfunction : bank_of

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [2:0] stb;
      logic [1:0] b;
      logic       cke;
      logic       act;
      logic       fp;
      stb = {link.row_strobe_n, link.col_strobe_n, link.write_en_n};
      b   = bank_of(link.bank_select_hi, link.bank_select_lo);
      cke = link.clk_en;
      act = |l_q.open;
      fp  = l_q.fp_sync[1];
      l_d = l_q;
      l_d.cke_prev = cke; // [R3]
      // Page mode comes from the clk side; two link flops before use
      l_d.fp_sync  = {l_q.fp_sync[0], full_page};
      l_d.cmd = SDC_NOP;
      if (l_q.burst != 8'h00 && l_q.mode == SDC_NORMAL) begin
         l_d.burst = (fp && l_q.burst == 8'h01) ? 8'h01 : l_q.burst - 8'h01;
      end
      // One cycle lag on suspend entry and exit
      if (l_q.susp_pend) begin // [R12]
         l_d.mode      = SDC_SUSP;
         l_d.susp_pend = 1'b0;
      end
      if (l_q.res_pend) begin // [R12]
         l_d.mode     = SDC_NORMAL;
         l_d.res_pend = 1'b0;
      end
      case (l_q.mode)
         SDC_SELFREF: begin
            if (cke) begin // [R11]
               l_d.mode = SDC_NORMAL;
            end
         end
         SDC_PWRDN: begin
            if (!l_q.cke_prev && cke) begin // [R8]
               l_d.mode = SDC_NORMAL;
            end
         end
         SDC_SUSP: begin
            if (!l_q.cke_prev && cke) begin // [R9]
               l_d.res_pend = 1'b1;
            end
         end
         SDC_NORMAL: begin
            // Enable back high during the lag edge would otherwise be lost
            if (l_q.susp_pend && !l_q.cke_prev && cke) begin // [R9]
               l_d.res_pend = 1'b1;
            end
            if (l_q.cke_prev && !cke) begin
               if (!link.chip_sel_n && stb == STB_REF && !act) begin // [R3]
                  l_d.mode = SDC_SELFREF;
                  l_d.cmd  = SDC_SREF;
               end else if (act || l_q.burst != 8'h00) begin // [R6] [R9]
                  l_d.susp_pend = 1'b1;
               end else if (link.chip_sel_n || stb == STB_NOP) begin // [R7]
                  l_d.mode = SDC_PWRDN;
               end
            end else if (l_q.cke_prev && !l_q.susp_pend && !link.chip_sel_n) begin // [R1]
               case (stb) // [R2]
                  STB_ACT: begin
                     l_d.open[b] = 1'b1;
                     l_d.cmd = SDC_ACT;
                  end
                  STB_PRE: begin
                     if (link.precharge_select_bit) begin // [R10]
                        l_d.open = '0;
                        l_d.cmd  = SDC_PREA;
                     end else begin
                        l_d.open[b] = 1'b0;
                        l_d.cmd = SDC_PRE;
                     end
                  end
                  STB_WR, STB_RD: begin
                     if (l_q.open[b]) begin // [R4]
                        l_d.cmd   = (stb == STB_WR) ? SDC_WR : SDC_RD;
                        l_d.apre  = link.precharge_select_bit; // [R10]
                        l_d.abank = b;
                        l_d.burst = 8'(BURST_LEN);
                     end
                  end
                  STB_MRS: l_d.cmd = SDC_MRS;
                  STB_REF: l_d.cmd = SDC_REF; // [R3]
                  STB_BST: begin
                     if (fp) begin // [R5]
                        l_d.burst = 8'h00;
                        l_d.cmd   = SDC_BST;
                     end
                  end
                  default: l_d.cmd = SDC_NOP;
               endcase
            end
         end
         default: l_d.mode = SDC_NORMAL;
      endcase
      if (l_q.apre && l_q.burst == 8'h01 && l_d.burst == 8'h00) begin
         l_d.open[l_q.abank] = 1'b0; // [R10]
         l_d.apre = 1'b0;
      end
      // Mask acts only with a bank open and outside suspend
      l_d.wr_en = act && !link.data_mask && l_q.mode == SDC_NORMAL; // [R13]
      l_d.rd_en = act && !link.data_mask && l_q.mode == SDC_NORMAL; // [R13]
      // Toggle every rising link edge so the clk side takes the fields once per period, cmd only when not NOP
      l_d.tog = ~l_q.tog;
   end

   always_ff @(posedge link.link_clk or posedge rst) begin // [R1]
      if (rst) begin
         l_q <= '{cke_prev: 1'b1, mode: SDC_NORMAL, susp_pend: 1'b0, res_pend: 1'b0,
                  open: '0, burst: 8'h00, apre: 1'b0, cmd: SDC_NOP, tog: 1'b0,
                  abank: '0, fp_sync: 2'h0,
                  wr_en: 1'b0, rd_en: 1'b0};
      end else begin
         l_q <= l_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Two stages before use; the link clock is far slower so fields settle first
   always_comb begin
      c_d = c_q;
      c_d.tsync = {c_q.tsync[1:0], l_q.tog};
      c_d.stb   = 1'b0;
      if (c_q.tsync[2] ^ c_q.tsync[1]) begin
         c_d.stb = l_q.cmd != SDC_NOP;
         if (l_q.cmd != SDC_NOP) begin
            c_d.cmd = l_q.cmd;
         end
         c_d.open  = l_q.open;
         c_d.apre  = l_q.apre;
         c_d.mode  = l_q.mode;
         c_d.burst = l_q.burst != 8'h00;
         c_d.wr    = l_q.wr_en;
         c_d.rd    = l_q.rd_en;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         c_q <= '{tsync: 3'h0, cmd: SDC_NOP, stb: 1'b0, open: '0, apre: 1'b0,
                  mode: SDC_NORMAL, burst: 1'b0, wr: 1'b0, rd: 1'b0};
      end else begin
         c_q <= c_d;
      end
   end

   assign cmd_out       = c_q.cmd;
   assign cmd_stb       = c_q.stb;
   assign bank_open     = c_q.open;
   assign auto_pre      = c_q.apre;
   assign mode          = c_q.mode;
   assign in_burst      = c_q.burst;
   assign wr_capture_en = c_q.wr;
   assign rd_drive_en   = c_q.rd;
endmodule : sdc_dev

//--- logic/sdc_if.sv
`timescale 1ns/1ps
interface sdc_if;
   logic       link_clk;
   logic       clk_en;
   logic       chip_sel_n;
   logic       row_strobe_n;
   logic       col_strobe_n;
   logic       write_en_n;
   logic       bank_select_lo;
   logic       bank_select_hi;
   logic       precharge_select_bit;
   logic       data_mask;

   modport ctrl (output link_clk, clk_en, chip_sel_n, row_strobe_n, col_strobe_n,
                 write_en_n, bank_select_lo, bank_select_hi, precharge_select_bit,
                 data_mask);
   modport dev  (input link_clk, clk_en, chip_sel_n, row_strobe_n, col_strobe_n,
                 write_en_n, bank_select_lo, bank_select_hi, precharge_select_bit,
                 data_mask);
endinterface : sdc_if

//--- logic/sdc_pkg.sv
// Function
// [R1] Commands sampled only on rising link clock
// [R2] Chip-select-low strobes decode the seven commands
// [R3] Refresh: clock-enable pair picks auto or self
// [R4] Read or write only to active bank
// [R5] Burst stop only during full-page burst; the device accepts it whenever full page is set, burst running or not
// [R6] Power-down request mid-burst becomes clock suspend
// [R7] Power-down entry on enable falling, deselect/nop
// [R8] Power-down exit on enable rising, deselect/nop
// [R9] Active bank: enable low suspends, high resumes
// [R10] Precharge bit: auto-precharge or close all banks
// [R11] Self-refresh ignores all but clock enable
// [R12] Suspend and resume lag one cycle
// [R13] Data mask gates write capture and drive
package sdc_pkg;
   localparam int NUM_BANKS = 4;
   localparam int BANK_W    = 2;
   localparam int CLK_DIV   = 8;   // Link clock period in system clocks, even
   localparam int LINK_NS   = 125;
   localparam int SYS_NS    = 8;
   localparam int HALF_CNT  = (LINK_NS / SYS_NS + 1) / 2;

   typedef enum logic [3:0] {
      SDC_NOP, SDC_ACT, SDC_PRE, SDC_PREA, SDC_WR, SDC_RD, SDC_MRS,
      SDC_BST, SDC_REF, SDC_SREF, SDC_DESEL
   } sdc_cmd_t;

   typedef enum logic [2:0] {
      SDC_NORMAL, SDC_PWRDN, SDC_SUSP, SDC_SELFREF
   } sdc_mode_t;

   // Strobe encodings {row, column, write}, active low
   localparam logic [2:0] STB_ACT = 3'h3;
   localparam logic [2:0] STB_PRE = 3'h2;
   localparam logic [2:0] STB_WR  = 3'h4;
   localparam logic [2:0] STB_RD  = 3'h5;
   localparam logic [2:0] STB_MRS = 3'h0;
   localparam logic [2:0] STB_REF = 3'h1;
   localparam logic [2:0] STB_NOP = 3'h7;
   localparam logic [2:0] STB_BST = 3'h6;
endpackage : sdc_pkg

//--- tb/sdc_sva.sv
`timescale 1ns/1ps
module sdc_sva
   import sdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic clk_en,
   input wire logic chip_sel_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_en_n,
   input wire logic bank_select_lo,
   input wire logic bank_select_hi,
   input wire logic precharge_select_bit,
   input wire logic data_mask
);
   logic [2:0] stb;
   logic       idle;
   assign stb  = {row_strobe_n, col_strobe_n, write_en_n};
   assign idle = chip_sel_n || (stb == STB_NOP);
   ////////////////////////////////////////////////////////////////////////////////
   // One link period: four clocks high, four low
   sequence s_high4;
      link_clk [*4];
   endsequence
   sequence s_low4;
      !link_clk [*4];
   endsequence
   a_link_period: assert property (@(posedge clk) disable iff (rst)
      $rose(link_clk) |-> s_high4 ##1 s_low4) else $error("link clock period off");
   // Pins may only move while the device cannot sample them
   a_strobe_hold: assert property (@(posedge clk) disable iff (rst)
      link_clk |-> $stable({chip_sel_n, stb})) else $error("strobes moved on high clock");
   a_ctl_hold: assert property (@(posedge clk) disable iff (rst)
      link_clk |-> $stable({clk_en, bank_select_hi, bank_select_lo, precharge_select_bit,
                            data_mask})) else $error("controls moved on high clock");
   a_reset_idle: assert property (@(posedge clk)
      $fell(rst) |-> chip_sel_n && clk_en && !link_clk && data_mask)
      else $error("link not idle out of reset");
   a_entry_code: assert property (@(posedge link_clk) disable iff (rst)
      $fell(clk_en) |-> idle || (!chip_sel_n && stb == STB_REF))
      else $error("enable fell with a live command");
   a_exit_code: assert property (@(posedge link_clk) disable iff (rst)
      $rose(clk_en) |-> idle) else $error("enable rose with a live command");
endmodule : sdc_sva

//--- tb/tb_sdram_command_decoder.sv
`timescale 1ns/1ps
module tb_sdram_command_decoder;
   import sdc_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b0;
   logic        req_valid = 1'b0;
   sdc_cmd_t    req_cmd = SDC_NOP;
   logic [1:0]  req_bank = 2'h0;
   logic        req_apre = 1'b0;
   logic        req_cke = 1'b1;
   logic        req_mask = 1'b1;
   logic        full_page = 1'b0;
   logic        req_ready;
   sdc_cmd_t    cmd_out;
   logic        cmd_stb;
   logic [3:0]  bank_open;
   logic        auto_pre;
   sdc_mode_t   mode;
   logic        in_burst;
   logic        wr_capture_en;
   logic        rd_drive_en;
   sdc_mode_t   m_mode = SDC_NORMAL;
   logic [3:0]  m_banks = 4'h0;
   logic        m_cke = 1'b1;
   logic        m_burst = 1'b0;
   logic [31:0] rng = 32'ha540;
   sdc_cmd_t    rc;
   sdc_cmd_t    sel[4] = '{SDC_ACT, SDC_RD, SDC_WR, SDC_PRE};
   sdc_cmd_t    exp_q[$];
   sdc_cmd_t    got_q[$];
   int          error_cnt = 0;
   int          num_checks = 0;
   int          cycles = 0;
   sdc_if u_sdc_if ();
   sdc_ctrl u_sdc_ctrl (.clk(clk), .rst(rst), .link(u_sdc_if), .req_valid(req_valid),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_apre(req_apre), .req_cke(req_cke),
      .req_mask(req_mask), .req_ready(req_ready));
   sdc_dev u_sdc_dev (.clk(clk), .rst(rst), .link(u_sdc_if), .full_page(full_page),
      .cmd_out(cmd_out), .cmd_stb(cmd_stb), .bank_open(bank_open), .auto_pre(auto_pre),
      .mode(mode), .in_burst(in_burst), .wr_capture_en(wr_capture_en),
      .rd_drive_en(rd_drive_en));
   sdc_sva u_sdc_sva (.clk(clk), .rst(rst), .link_clk(u_sdc_if.link_clk),
      .clk_en(u_sdc_if.clk_en), .chip_sel_n(u_sdc_if.chip_sel_n),
      .row_strobe_n(u_sdc_if.row_strobe_n), .col_strobe_n(u_sdc_if.col_strobe_n),
      .write_en_n(u_sdc_if.write_en_n), .bank_select_lo(u_sdc_if.bank_select_lo),
      .bank_select_hi(u_sdc_if.bank_select_hi), .data_mask(u_sdc_if.data_mask),
      .precharge_select_bit(u_sdc_if.precharge_select_bit));
   ////////////////////////////////////////////////////////////////////////////////
   always #4 clk = ~clk;
   // Strobed commands, fillers dropped so the model stays short
   always @(posedge clk) begin
      cycles++;
      if (cmd_stb === 1'b1 && cmd_out !== SDC_NOP && cmd_out !== SDC_DESEL)
         got_q.push_back(cmd_out);
      if (cycles > 4000) begin
         error_cnt++;
         print_verdict();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   task automatic chk(input logic ok, input string what);
      num_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : chk
   task automatic chk_cmd(input sdc_cmd_t got, input sdc_cmd_t exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: command %s not %s", $time, got.name(), exp.name());
      end
   endtask : chk_cmd
   // Valid stays high, so slots run back to back
   task automatic slot(input sdc_cmd_t c, input logic [1:0] b, input logic ap, ke, mk);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_cmd = c;
      req_bank = b;
      req_apre = ap;
      req_cke = ke;
      req_mask = mk;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 40);
      #1;
   endtask : slot
   task automatic issue(input sdc_cmd_t c, input logic [1:0] b, input logic ap, ke, mk);
      logic skip;
      skip = ap && (c inside {SDC_RD, SDC_WR});
      slot(c, b, ap, ke, mk);
      repeat (3) slot(SDC_NOP, b, 1'b0, ke, mk);
      if (m_mode != SDC_NORMAL) begin
         if (ke) m_mode = SDC_NORMAL;
      end else if (m_cke && !ke) begin
         if (c == SDC_REF && m_banks == 4'h0) exp_q.push_back(SDC_SREF);
         m_mode = (c == SDC_REF && m_banks == 4'h0) ? SDC_SELFREF :
                  (m_banks != 4'h0) ? SDC_SUSP : SDC_PWRDN;
      end else begin
         if (c == SDC_ACT) m_banks[b] = 1'b1;
         if (c == SDC_PRE) m_banks[b] = 1'b0;
         if (c == SDC_PREA) m_banks = 4'h0;
         if (c inside {SDC_ACT, SDC_PRE, SDC_PREA, SDC_MRS, SDC_REF} ||
             (c inside {SDC_RD, SDC_WR} && m_banks[b]) || (c == SDC_BST && full_page))
            exp_q.push_back(c);
         // A short burst ends by the next command; a full page runs until stopped
         m_burst = (c inside {SDC_RD, SDC_WR} && m_banks[b]) ||
                   (full_page && m_burst && c != SDC_BST);
      end
      m_cke = ke;
      chk(mode === m_mode, "mode");
      chk(skip || bank_open === m_banks, "open banks");
      chk(in_burst === m_burst, "burst");
      if (m_mode == SDC_NORMAL && !skip) begin
         chk(wr_capture_en === ((|m_banks) && !mk), "write capture");
         chk(rd_drive_en === ((|m_banks) && !mk), "read drive");
      end
      while (exp_q.size() > 0) chk_cmd((got_q.size() > 0) ? got_q.pop_front() : SDC_NOP,
                                       exp_q.pop_front());
      chk(got_q.size() == 0, "unexpected command");
      got_q.delete();
      // Auto-precharge closes the addressed bank once its burst ends
      if (skip) m_banks[b] = 1'b0;
   endtask : issue
   task automatic test_done(input string name);
      $display("test %s finished", name);
   endtask : test_done
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      // A real reset edge; the link-clocked end has no clock edge while reset holds
      #1;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      issue(SDC_MRS, 2'h0, 1'b0, 1'b1, 1'b1);
      issue(SDC_REF, 2'h0, 1'b0, 1'b1, 1'b1);
      issue(SDC_ACT, 2'h1, 1'b0, 1'b1, 1'b0);
      issue(SDC_WR, 2'h1, 1'b0, 1'b1, 1'b0);
      issue(SDC_RD, 2'h2, 1'b0, 1'b1, 1'b0);
      issue(SDC_BST, 2'h1, 1'b0, 1'b1, 1'b1);
      full_page = 1'b1;
      issue(SDC_RD, 2'h1, 1'b0, 1'b1, 1'b1);
      chk(auto_pre === 1'b0, "plain read");
      issue(SDC_BST, 2'h1, 1'b0, 1'b1, 1'b1);
      full_page = 1'b0;
      issue(SDC_RD, 2'h1, 1'b1, 1'b1, 1'b0);
      chk(auto_pre === 1'b1, "auto precharge read");
      issue(SDC_PREA, 2'h2, 1'b1, 1'b1, 1'b1);
      test_done("decode");
      issue(SDC_ACT, 2'h0, 1'b0, 1'b1, 1'b0);
      issue(SDC_NOP, 2'h0, 1'b0, 1'b0, 1'b0);
      issue(SDC_ACT, 2'h2, 1'b0, 1'b0, 1'b0);
      issue(SDC_NOP, 2'h0, 1'b0, 1'b1, 1'b0);
      issue(SDC_REF, 2'h0, 1'b0, 1'b0, 1'b1);
      issue(SDC_NOP, 2'h0, 1'b0, 1'b1, 1'b1);
      issue(SDC_PRE, 2'h0, 1'b0, 1'b1, 1'b1);
      test_done("suspend");
      issue(SDC_DESEL, 2'h0, 1'b0, 1'b0, 1'b1);
      issue(SDC_NOP, 2'h0, 1'b0, 1'b1, 1'b1);
      issue(SDC_REF, 2'h0, 1'b0, 1'b0, 1'b1);
      issue(SDC_MRS, 2'h0, 1'b0, 1'b0, 1'b1);
      issue(SDC_NOP, 2'h0, 1'b0, 1'b1, 1'b1);
      test_done("low power");
      for (int i = 0; i < 10; i++) begin
         rng = xs(rng);
         rc = sel[rng[3:2]];
         if (rc == SDC_ACT && m_banks[rng[1:0]]) rc = SDC_WR;
         issue(rc, rng[1:0], 1'b0, 1'b1, rng[4]);
      end
      test_done("random traffic");
      print_verdict();
   end
endmodule : tb_sdram_command_decoder
